/* File: common/tto_pkg.sv */
// Shared constants and helpers for the tick and tone timer
package tto_pkg;

  // Bus widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  typedef logic [ADDR_W-1:0] tto_addr_t;
  typedef logic [DATA_W-1:0] tto_data_t;

  // Register byte offsets
  localparam tto_addr_t ADDR_CTRL = 8'h00;
  localparam tto_addr_t ADDR_CFG = 8'h04;
  localparam tto_addr_t ADDR_IRQ_STAT = 8'h08;
  localparam tto_addr_t ADDR_IRQ_MASK = 8'h0c;
  localparam tto_addr_t ADDR_DIV_STATE = 8'h10;

  // Field positions in tick_tone_control
  localparam int CTRL_TICK_RATE_LSB = 0;
  localparam int CTRL_TICK_RATE_MSB = 2;
  localparam int CTRL_TICK_EN_BIT = 3;
  localparam int CTRL_TONE_RATE_LSB = 5;
  localparam int CTRL_TONE_RATE_MSB = 6;
  localparam int CTRL_TONE_EN_BIT = 7;
  localparam tto_data_t CTRL_WR_MASK = 8'hef;

  // Field positions in the configuration register
  localparam int CFG_SRC_BIT = 0;
  localparam int CFG_SLOW_BIT = 1;

  // Interrupt status and mask layout
  localparam int IRQ_TICK_BIT = 0;

  // Values after reset
  localparam tto_data_t CTRL_RST = 8'h00;
  localparam logic [1:0] CFG_RST = 2'h0;
  localparam logic [0:0] MASK_RST = 1'h0;
  localparam logic [0:0] STAT_RST = 1'h0;

  // Divider chain lengths
  localparam int FC_DIV_WIDTH = 23;
  localparam int FS_DIV_WIDTH = 15;

  // Highest tick code usable in slow mode
  localparam logic [2:0] TICK_SLOW_MAX_CODE = 3'h1;

  // Divider exponent: tap period is 2 to this power
  typedef logic [4:0] tto_exp_t;

  // Tick exponents on the high-frequency source
  function automatic tto_exp_t fc_tick_exp(input logic [2:0] code);
    case (code)
      3'h0: fc_tick_exp = 5'h17;
      3'h1: fc_tick_exp = 5'h15;
      3'h2: fc_tick_exp = 5'h10;
      3'h3: fc_tick_exp = 5'h0e;
      3'h4: fc_tick_exp = 5'h0d;
      3'h5: fc_tick_exp = 5'h0c;
      3'h6: fc_tick_exp = 5'h0b;
      default: fc_tick_exp = 5'h09;
    endcase
  endfunction

  // Tick exponents on the low-frequency source
  function automatic tto_exp_t fs_tick_exp(input logic [2:0] code);
    case (code)
      3'h0: fs_tick_exp = 5'h0f;
      3'h1: fs_tick_exp = 5'h0d;
      3'h2: fs_tick_exp = 5'h08;
      3'h3: fs_tick_exp = 5'h06;
      3'h4: fs_tick_exp = 5'h05;
      3'h5: fs_tick_exp = 5'h04;
      3'h6: fs_tick_exp = 5'h03;
      default: fs_tick_exp = 5'h01;
    endcase
  endfunction

  // Tone exponents; each higher code halves the period
  function automatic tto_exp_t fc_tone_exp(input logic [1:0] code);
    fc_tone_exp = 5'h0d - {3'h0, code};
  endfunction

  function automatic tto_exp_t fs_tone_exp(input logic [1:0] code);
    fs_tone_exp = 5'h05 - {3'h0, code};
  endfunction

endpackage

/* File: common/tto_div_if.sv */
// Divider count and step between the top and a divider stage
`timescale 1ns/1ps
interface tto_div_if #(parameter int WIDTH = 23) ();
  logic step;
  logic [WIDTH-1:0] count;

  // Divider side
  modport cnt (input step, output count);
  // User side
  modport tap (output step, input count);
endinterface

/* File: rtl/tto_divider.sv */
// Free-running binary divider chain advanced by a step enable
`timescale 1ns/1ps
module tto_divider #(
  parameter int WIDTH = 23
) (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  tto_div_if.cnt div
);
  import tto_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] count;
  } tto_div_s;

  tto_div_s div_ff;
  tto_div_s nxt_div;

  // Width check
  if (WIDTH < 2) begin : g_bad_width
    $error("tto_divider width below two");
  end

  // Advance on each step; never cleared by software
  always_comb
  begin
    nxt_div = div_ff;
    if (div.step)
    begin
      nxt_div.count = div_ff.count + WIDTH'(1); // RL5
    end
  end

  // State register
  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      div_ff <= '0;
    end
    else
    begin
      div_ff <= nxt_div;
    end
  end

  assign div.count = div_ff.count;

  // Divider advances on every step; no control change clears it
  count_step_a: assert property ( // RL5
    @(posedge i_sys_clk) disable iff (!i_reset_n)
    div.step |=> div.count == $past(div.count) + WIDTH'(1))
    else $error("divider did not advance on step");

  count_hold_a: assert property ( // RL5
    @(posedge i_sys_clk) disable iff (!i_reset_n)
    !div.step |=> $stable(div.count))
    else $error("divider moved without step");

endmodule

/* File: rtl/tto_top.sv */
// Tick interrupt generator and square-wave tone output with register port
`timescale 1ns/1ps
// Function
// [RL1] Periodic tick raises an interrupt request at a software-chosen rate.
// [RL2] Software changes tick rate only while the tick unit is disabled.
// [RL3] One write may set tick rate and tick enable together.
// [RL4] Tick request on each falling edge of the selected divider tap.
// [RL5] Enabling never clears the divider, so the first tick may be early.
// [RL6] Tick code 010 gives fc over 2^16 on the fast source.
// [RL7] Three-bit tick code: 000 slowest, 111 fastest of eight rates.
// [RL8] Tone enable drives a near 50 percent duty square wave on the pin.
// [RL9] Software changes tone rate only while the tone output is disabled.
// [RL10] Tone code 00 is fc over 2^13; each higher code doubles it.
// [RL11] Tick divide ratios per source; codes 010 up blocked in slow mode.
// [RL12] Control: tick rate bits 2-0, tick enable 3, tone 6-5, enable 7.
module tto_top #(
  parameter int SIM_SHIFT = 0
) (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic i_fs_en,
  input wire tto_pkg::tto_addr_t i_addr,
  input wire tto_pkg::tto_data_t i_wr_data,
  input wire logic i_wr,
  input wire logic i_rd,
  output tto_pkg::tto_data_t o_rd_data,
  output logic o_irq,
  output logic o_tick_interrupt_request,
  output logic o_tone_pin_n
);
  import tto_pkg::*;

  // Shortens every fast-source tap for simulation
  localparam tto_exp_t SHIFT_E = tto_exp_t'(SIM_SHIFT);

  if (SIM_SHIFT < 0 || SIM_SHIFT > 8) begin : g_bad_shift
    $error("tto_top SIM_SHIFT outside 0 to 8");
  end

  typedef struct packed {
    tto_data_t ctrl;
    logic [1:0] cfg;
    logic [0:0] stat;
    logic [0:0] mask;
    tto_data_t rd_data;
    logic irq;
    logic tick_req;
    logic tone_n;
  } tto_top_s;

  localparam tto_top_s STATE_RST = '{
    ctrl: CTRL_RST,
    cfg: CFG_RST,
    stat: STAT_RST,
    mask: MASK_RST,
    rd_data: 8'h00,
    irq: 1'b0,
    tick_req: 1'b0,
    tone_n: 1'b1
  };

  tto_top_s state_ff;
  tto_top_s nxt_state;

  logic slow_mode;
  logic src_fs;
  logic tick_en;
  logic tone_en;
  logic [2:0] tick_rate;
  logic [1:0] tone_rate;
  tto_exp_t tick_e;
  tto_exp_t tone_e;
  logic [FC_DIV_WIDTH-1:0] tap_cnt;
  logic tap_step;
  logic tick_allowed;
  logic tick_ev;
  logic tone_lvl;

  // Two divider chains: fast clock every cycle outside slow mode, slow clock on its enable
  tto_div_if #(.WIDTH(FC_DIV_WIDTH)) fc_if ();
  tto_div_if #(.WIDTH(FS_DIV_WIDTH)) fs_if ();

  assign fc_if.step = !slow_mode;
  assign fs_if.step = i_fs_en;

  tto_divider #(.WIDTH(FC_DIV_WIDTH)) u_fc_div (
    .i_sys_clk(i_sys_clk),
    .i_reset_n(i_reset_n),
    .div(fc_if.cnt)
  );

  tto_divider #(.WIDTH(FS_DIV_WIDTH)) u_fs_div (
    .i_sys_clk(i_sys_clk),
    .i_reset_n(i_reset_n),
    .div(fs_if.cnt)
  );

  // True when the low e bits are all ones, the step before a tap falls
  function automatic logic ones_below(input logic [FC_DIV_WIDTH-1:0] c, input tto_exp_t e);
    logic r;
    r = 1'b1;
    for (int i = 0; i < FC_DIV_WIDTH; i++)
    begin
      if (i < int'(e) && !c[i])
      begin
        r = 1'b0;
      end
    end
    return r;
  endfunction

  // Field decode of the control and configuration registers
  always_comb
  begin
    tick_rate = state_ff.ctrl[CTRL_TICK_RATE_MSB:CTRL_TICK_RATE_LSB]; // RL12
    tick_en = state_ff.ctrl[CTRL_TICK_EN_BIT]; // RL12
    tone_rate = state_ff.ctrl[CTRL_TONE_RATE_MSB:CTRL_TONE_RATE_LSB]; // RL12
    tone_en = state_ff.ctrl[CTRL_TONE_EN_BIT]; // RL12
    slow_mode = state_ff.cfg[CFG_SLOW_BIT];
    src_fs = state_ff.cfg[CFG_SRC_BIT] | slow_mode;
  end

  // Tap selection and falling-edge detection
  always_comb
  begin
    if (src_fs)
    begin
      tick_e = fs_tick_exp(tick_rate); // RL11
      tone_e = fs_tone_exp(tone_rate);
      tap_cnt = FC_DIV_WIDTH'(fs_if.count);
      tap_step = fs_if.step;
    end
    else
    begin
      tick_e = fc_tick_exp(tick_rate) - SHIFT_E; // RL6 RL7 RL11
      tone_e = fc_tone_exp(tone_rate) - SHIFT_E; // RL10
      tap_cnt = fc_if.count;
      tap_step = fc_if.step;
    end
    tick_allowed = !(slow_mode && tick_rate > TICK_SLOW_MAX_CODE); // RL11
    tick_ev = tap_step && ones_below(tap_cnt, tick_e) && tick_allowed; // RL4 RL5
    tone_lvl = tap_cnt[tone_e - 5'h01]; // RL8
  end

  // Register writes, sticky status, read port and outputs
  always_comb
  begin
    nxt_state = state_ff;
    nxt_state.rd_data = 8'h00;
    if (i_wr)
    begin
      case (i_addr)
        ADDR_CTRL: nxt_state.ctrl = i_wr_data & CTRL_WR_MASK; // RL3 RL12
        ADDR_CFG: nxt_state.cfg = i_wr_data[CFG_SLOW_BIT:CFG_SRC_BIT];
        ADDR_IRQ_MASK: nxt_state.mask = i_wr_data[IRQ_TICK_BIT];
        default: nxt_state.cfg = state_ff.cfg;
      endcase
    end
    if (i_rd)
    begin
      case (i_addr)
        ADDR_CTRL: nxt_state.rd_data = state_ff.ctrl;
        ADDR_CFG: nxt_state.rd_data = {6'h00, state_ff.cfg};
        ADDR_IRQ_STAT: nxt_state.rd_data = {7'h00, state_ff.stat};
        ADDR_IRQ_MASK: nxt_state.rd_data = {7'h00, state_ff.mask};
        ADDR_DIV_STATE: nxt_state.rd_data = fc_if.count[FC_DIV_WIDTH-1 -: DATA_W];
        default: nxt_state.rd_data = 8'h00;
      endcase
      if (i_addr == ADDR_IRQ_STAT)
      begin
        nxt_state.stat = 1'b0;
      end
    end
    // Set after clear so a coinciding tick is kept
    nxt_state.tick_req = tick_ev && tick_en; // RL1 RL4
    if (tick_ev && tick_en)
    begin
      nxt_state.stat[IRQ_TICK_BIT] = 1'b1; // RL1
    end
    nxt_state.irq = |(nxt_state.stat & nxt_state.mask);
    // Pin idles high while the tone is off
    nxt_state.tone_n = tone_en ? tone_lvl : 1'b1; // RL8
  end

  // State register
  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      state_ff <= STATE_RST;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  assign o_rd_data = state_ff.rd_data;
  assign o_irq = state_ff.irq;
  assign o_tick_interrupt_request = state_ff.tick_req;
  assign o_tone_pin_n = state_ff.tone_n;

  // Checks on the tick and tone paths
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_reset_n);

  // Fast-source taps of this instance, shortened like the divider taps
  localparam int TAP_010_E = 16 - SIM_SHIFT;
  localparam int TAP_111_E = 9 - SIM_SHIFT;
  localparam int TONE_00_BIT = 12 - SIM_SHIFT;
  localparam logic [FC_DIV_WIDTH-1:0] ONES_010 = FC_DIV_WIDTH'((64'h1 << TAP_010_E) - 64'h1);
  localparam logic [FC_DIV_WIDTH-1:0] ONES_111 = FC_DIV_WIDTH'((64'h1 << TAP_111_E) - 64'h1);

  sequence s_en_rate_write;
    i_wr && i_addr == ADDR_CTRL && i_wr_data[CTRL_TICK_EN_BIT];
  endsequence

  sequence s_stat_read_quiet;
    i_rd && i_addr == ADDR_IRQ_STAT && !(tick_ev && tick_en);
  endsequence

  property p_en_rate_write;
    s_en_rate_write |=> tick_en && tick_rate == $past(i_wr_data[2:0]);
  endproperty

  property p_stat_read_clear;
    s_stat_read_quiet |=> !state_ff.stat[IRQ_TICK_BIT] ##0 o_rd_data[IRQ_TICK_BIT] ==
      $past(state_ff.stat[IRQ_TICK_BIT]);
  endproperty

  enable_rate_write_a: assert property (p_en_rate_write) // RL3
    else $error("combined rate and enable write not taken");

  tick_edge_req_a: assert property ( // RL4
    tick_ev && tick_en |=> o_tick_interrupt_request && state_ff.stat[IRQ_TICK_BIT])
    else $error("tick edge did not raise request");

  tick_off_quiet_a: assert property ( // RL1
    !tick_en |=> !o_tick_interrupt_request)
    else $error("tick request while disabled");

  code_010_rate_a: assert property ( // RL6
    tick_en && !src_fs && tick_rate == 3'h2 && (fc_if.count & ONES_010) == ONES_010
    |=> o_tick_interrupt_request)
    else $error("code 010 tick missed its fc tap");

  code_010_gap_a: assert property ( // RL6
    tick_en && !src_fs && tick_rate == 3'h2 && (fc_if.count & ONES_010) != ONES_010
    |=> !o_tick_interrupt_request)
    else $error("code 010 tick off its fc tap");

  slow_code_block_a: assert property ( // RL11
    slow_mode && tick_rate > TICK_SLOW_MAX_CODE |=> !o_tick_interrupt_request)
    else $error("blocked code ticked in slow mode");

  fast_code_rate_a: assert property ( // RL7
    tick_en && !src_fs && tick_rate == 3'h7 && (fc_if.count & ONES_111) == ONES_111
    |=> o_tick_interrupt_request)
    else $error("code 111 tick missed its fc tap");

  tone_idle_a: assert property ( // RL8
    !tone_en |=> o_tone_pin_n)
    else $error("tone pin not idle high");

  tone_code_00_a: assert property ( // RL10
    tone_en && !src_fs && tone_rate == 2'h0
    |=> o_tone_pin_n == $past(fc_if.count[TONE_00_BIT]))
    else $error("tone code 00 not on its fc tap");

  stat_read_clear_a: assert property (p_stat_read_clear) // RL1
    else $error("status read did not clear");

  irq_level_a: assert property ( // RL1
    o_irq == |(state_ff.stat & state_ff.mask))
    else $error("interrupt level not status and mask");

  fs_code_011_a: assert property ( // RL11
    tick_en && src_fs && !slow_mode && tick_rate == 3'h3 && fs_if.step &&
    fs_if.count[5:0] == 6'h3f |=> o_tick_interrupt_request)
    else $error("fs code 011 tick missed its tap");

  slow_fc_hold_a: assert property ( // RL11
    slow_mode |=> $stable(fc_if.count))
    else $error("fast divider ran in slow mode");

  fs_tone_00_a: assert property ( // RL10
    tone_en && src_fs && tone_rate == 2'h0 |=> o_tone_pin_n == $past(fs_if.count[4]))
    else $error("tone code 00 not on fs tap 4");

  rd_data_idle_a: assert property ( // RL12
    !i_rd |=> o_rd_data == 8'h00)
    else $error("read data stood beyond its cycle");

  irq_mask_off_a: assert property ( // RL1
    !state_ff.mask[IRQ_TICK_BIT] && !(i_wr && i_addr == ADDR_IRQ_MASK) |=> !o_irq)
    else $error("masked tick reached the interrupt");

endmodule

/* File: test/tto_buzzer_model.sv */
// Buzzer model that times the high and low halves of the tone pin
`timescale 1ns/1ps
module tto_buzzer_model (
  input wire logic i_clk,
  input wire logic i_tone_pin_n,
  output int o_high,
  output int o_low
);
  int run = 0;
  logic last = 1'b1;

  // Length of each pin level in clock cycles, logged on every change
  always @(posedge i_clk)
  begin
    run <= run + 1;
    last <= i_tone_pin_n;
    if (i_tone_pin_n !== last)
    begin
      if (last === 1'b1)
        o_high <= run;
      else
        o_low <= run;
      run <= 1;
    end
  end
endmodule

/* File: test/time_base_tick_and_tone_output_tb.sv */
// Self-checking bench for the tick and tone timer
`timescale 1ns/1ps
module time_base_tick_and_tone_output_tb;
  import tto_pkg::*;
  logic i_sys_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic i_fs_en = 1'b0;
  tto_addr_t i_addr = 8'h00;
  tto_data_t i_wr_data = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  tto_data_t o_rd_data;
  logic o_irq;
  logic o_tick_interrupt_request;
  logic o_tone_pin_n;
  logic [1:0] fs_cnt = 2'h0;
  int hi_len;
  int lo_len;
  int miscompares = 0;
  int compares = 0;
  int cycles = 0;
  int n;
  tto_data_t d;
  int tick_exp [8] = '{15, 13, 8, 6, 5, 4, 3, 1};
  tto_addr_t zero_regs [6] = '{ADDR_CTRL, ADDR_CFG, ADDR_IRQ_STAT, ADDR_IRQ_MASK, ADDR_DIV_STATE,
    8'h14};

  tto_top #(.SIM_SHIFT(8)) dut (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n),
    .i_fs_en(i_fs_en), .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd),
    .o_rd_data(o_rd_data), .o_irq(o_irq),
    .o_tick_interrupt_request(o_tick_interrupt_request), .o_tone_pin_n(o_tone_pin_n));
  tto_buzzer_model buzzer (.i_clk(i_sys_clk), .i_tone_pin_n(o_tone_pin_n),
    .o_high(hi_len), .o_low(lo_len));

  // Clock and slow-source step, one pulse every four cycles
  always #5 i_sys_clk = ~i_sys_clk;
  always @(posedge i_sys_clk)
  begin
    fs_cnt <= fs_cnt + 2'h1;
    i_fs_en <= (fs_cnt == 2'h3);
  end

  // Hang guard; the tests need about 20000 cycles
  always @(posedge i_sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 60000)
    begin
      miscompares++;
      stop_test();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic wr(input tto_addr_t a, input tto_data_t v);
    @(posedge i_sys_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wr_data <= v;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input tto_addr_t a, output tto_data_t v);
    @(posedge i_sys_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1;
    v = o_rd_data;
  endtask

  // Cycles from one tick pulse to the next
  task automatic tick_per(output int p);
    int k;
    k = 0;
    p = 0;
    do
    begin
      @(posedge i_sys_clk);
      #1;
      k++;
    end
    while (o_tick_interrupt_request !== 1'b1 && k < 20000);
    do
    begin
      @(posedge i_sys_clk);
      #1;
      p++;
    end
    while (o_tick_interrupt_request !== 1'b1 && p < 20000);
  endtask

  task automatic stop_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (16) @(posedge i_sys_clk);
    i_reset_n <= 1'b1;
    @(posedge i_sys_clk);
    #1;
    chk(o_tone_pin_n, 1'b1);
    chk(o_irq, 1'b0);
    // Reset values, a young divider and an unmapped place that ignores writes
    wr(8'h14, 8'hff);
    foreach (zero_regs[i])
    begin
      rd(zero_regs[i], d);
      chk(d, 8'h00);
    end
    wr(ADDR_CTRL, 8'hff);
    rd(ADDR_CTRL, d);
    chk(d, 8'hef);
    wr(ADDR_CTRL, 8'h67);
    // Tick period for codes 001 to 111; rate and enable set in one write
    for (int c = 1; c < 8; c++)
    begin
      wr(ADDR_CTRL, tto_data_t'(c - 1));
      wr(ADDR_CTRL, 8'h08 | tto_data_t'(c));
      tick_per(n);
      chk(n, 32'h1 << tick_exp[c]);
    end
    // Slow mode refuses fast codes
    wr(ADDR_CTRL, 8'h07);
    wr(ADDR_CFG, 8'h02);
    wr(ADDR_CTRL, 8'h0f);
    n = 0;
    repeat (300)
    begin
      @(posedge i_sys_clk);
      #1;
      if (o_tick_interrupt_request === 1'b1)
        n++;
    end
    chk(n, 0);
    // Slow source, code 011: 2^6 steps of four cycles
    wr(ADDR_CTRL, 8'h07);
    wr(ADDR_CFG, 8'h01);
    wr(ADDR_CTRL, 8'h0b);
    tick_per(n);
    chk(n, 256);
    // Stale status cleared, interrupt raised, read-cleared, then masked
    wr(ADDR_CTRL, 8'h03);
    wr(ADDR_CFG, 8'h00);
    rd(ADDR_IRQ_STAT, d);
    chk(d, 8'h01);
    wr(ADDR_IRQ_MASK, 8'h01);
    rd(ADDR_IRQ_MASK, d);
    chk(d, 8'h01);
    chk(o_irq, 1'b0);
    wr(ADDR_CTRL, 8'h0a);
    tick_per(n);
    chk(o_irq, 1'b1);
    rd(ADDR_IRQ_STAT, d);
    chk(d, 8'h01);
    rd(ADDR_IRQ_STAT, d);
    chk(d, 8'h00);
    chk(o_irq, 1'b0);
    wr(ADDR_IRQ_MASK, 8'h00);
    tick_per(n);
    chk(o_irq, 1'b0);
    rd(ADDR_IRQ_STAT, d);
    chk(d, 8'h01);
    rd(ADDR_IRQ_MASK, d);
    chk(d, 8'h00);
    // Tone: half period 2^(4-code) cycles with the shortened divider
    wr(ADDR_CTRL, 8'h02);
    for (int t = 0; t < 4; t++)
    begin
      wr(ADDR_CTRL, tto_data_t'(t << 5) | 8'h02);
      wr(ADDR_CTRL, tto_data_t'(t << 5) | 8'h82);
      repeat (80) @(posedge i_sys_clk);
      #1;
      chk(hi_len, 32'h1 << (4 - t));
      chk(lo_len, 32'h1 << (4 - t));
      wr(ADDR_CTRL, tto_data_t'(t << 5) | 8'h02);
      repeat (3) @(posedge i_sys_clk);
      #1;
      chk(o_tone_pin_n, 1'b1);
    end
    // Slow-source tone, code 00: half period of 2^4 steps of four cycles
    wr(ADDR_CTRL, 8'h02);
    wr(ADDR_CFG, 8'h01);
    wr(ADDR_CTRL, 8'h82);
    repeat (300) @(posedge i_sys_clk);
    #1;
    chk(hi_len, 64);
    chk(lo_len, 64);
    stop_test();
  end
endmodule
